/* File: logic/wepf_pkg.sv */
// wepf_pkg: shared constants and types for the wake event / power-off fence block
// assumes a 10 MHz sys_clk
package wepf_pkg;
	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS        = 100;
	localparam int unsigned RESEND_TIMEOUT_MS    = 100;
	localparam int unsigned RESEND_TIMEOUT_CYC   = RESEND_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned TIMER_W              = 20;
	// ------------------------------------------------------------
	// widths and reset values
	// ------------------------------------------------------------
	localparam int unsigned NUM_DS_PORTS         = 4;
	localparam int unsigned REQ_ID_W             = 16;
	localparam logic        PENDING_RST          = 1'b0;
	localparam logic        WAKE_OE_N_RST        = 1'b1;
	// ------------------------------------------------------------
	// wake delivery states
	// ------------------------------------------------------------
	typedef enum logic [1:0] {
		WEPF_COMM,
		WEPF_SENT,
		WEPF_NONCOMM,
		WEPF_REACT
	} wepf_state_t;
endpackage : wepf_pkg

/* File: logic/wepf_ack_if.sv */
// wepf_ack_if: carries per-port fence acknowledge and ready signals to the aggregator
// assumes one sys_clk domain
`timescale 1ns/1ps
interface wepf_ack_if;
	logic [wepf_pkg::NUM_DS_PORTS-1:0] ds_ack;
	logic [wepf_pkg::NUM_DS_PORTS-1:0] ds_ready;
	logic [wepf_pkg::NUM_DS_PORTS-1:0] ds_active;
	logic                              clear;
	logic                              all_acked;
	logic                              all_ready;
	modport top (output ds_ack, output ds_ready, output ds_active, output clear,
		input all_acked, input all_ready);
	modport agg (input ds_ack, input ds_ready, input ds_active, input clear,
		output all_acked, output all_ready);
endinterface : wepf_ack_if

/* File: logic/wepf_ack_agg.sv */
// wepf_ack_agg: scoreboard of downstream fence acknowledgements
// assumes inputs are synchronous to sys_clk
`timescale 1ns/1ps
module wepf_ack_agg (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// link to top
	wepf_ack_if.agg  agg
);
	logic [wepf_pkg::NUM_DS_PORTS-1:0] seen_q;

	// ------------------------------------------------------------
	// scoreboard
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || agg.clear) begin // see RULE16
			seen_q <= '0;
		end else begin
			seen_q <= seen_q | agg.ds_ack;
		end
	end

	// idle ports count as done
	assign agg.all_acked = &(seen_q | ~agg.ds_active); // see RULE15
	assign agg.all_ready = &(agg.ds_ready | ~agg.ds_active); // see RULE19
endmodule : wepf_ack_agg

/* File: logic/wepf_top.sv */
// wepf_top: wake event delivery and power-off fence for a downstream component
// assumes link pulses are sys_clk synchronous; wake_line and main_pwr are pins
//
// Summary of operation
// RULE1 - link wakeup is used only when the upstream link is non-communicating L2.
// RULE2 - every wake request carries the requester id of the originating function.
// RULE3 - a root port reports its own wake events through itself.
// RULE4 - event collector lists its integrated endpoints; each belongs to one collector.
// RULE5 - wakeup-capable component implements beacon unless sideband-only form factor.
// RULE6 - a bridging switch sends beacon upstream while sideband wake input asserted.
// RULE7 - sideband wake stays driven low until fundamental reset deasserts; here the line is released as soon as rst asserts.
// RULE8 - the endpoint never reads the sideband wake line as an input.
// RULE9 - wakeup used only while wake_event_enable is set by software.
// RULE10 - wake_event_pending survives reset when aux power and enable present.
// RULE11 - aux power drawn only after software enables it.
// RULE12 - after link retrains, the function sends its wake request upstream.
// RULE13 - fence message arrival blocks new wake requests at once; here the block takes effect one cycle after arrival, once fence_q is set.
// RULE14 - each receiver answers the fence with an acknowledgement sent upstream.
// RULE15 - switch sends one upstream acknowledgement after all downstream ports acked.
// RULE16 - aggregation clears on ack sent, upstream packet, power loss, or reset.
// RULE17 - endpoint acknowledges the fence regardless of device power state.
// RULE18 - after acknowledging, endpoint moves link toward ready-for-power-removal.
// RULE19 - switch upstream link goes ready only after all downstream ports ready.
// RULE20 - power manager times out waiting for acks in 1 to 10 ms.
// RULE21 - power manager waits 100 ns after ready before removing power.
// RULE22 - entry request packet repeats until acknowledged or power removed.
// RULE23 - still pending 100 ms after a request: resend, waking link first.
// RULE24 - sideband wake is open drain, enable low drives zero.
`timescale 1ns/1ps
module wepf_top (
	// clock and reset
	input  wire logic                               sys_clk,
	input  wire logic                               rst,
	// configuration
	input  wire logic                               is_switch,
	input  wire logic                               use_sideband,
	input  wire logic                               beacon_capable,
	input  wire logic [wepf_pkg::REQ_ID_W-1:0]      requester_id,
	// software control and status
	input  wire logic                               wake_event_enable,
	input  wire logic                               aux_pwr_enable,
	input  wire logic                               pending_clear,
	input  wire logic                               aux_present,
	output logic                                    wake_event_pending,
	output logic                                    aux_pwr_draw,
	// function event
	input  wire logic                               wake_event_in,
	// upstream link status and messages
	input  wire logic                               link_trained,
	input  wire logic                               power_off_fence_msg,
	input  wire logic                               us_tlp_rx,
	input  wire logic                               enter_ack_rx,
	output logic                                    wake_request_msg,
	output logic [wepf_pkg::REQ_ID_W-1:0]           wake_request_id,
	output logic                                    power_off_fence_ack,
	output logic                                    enter_poweroff_ready_pkt,
	output logic                                    ready_for_power_removal,
	output logic                                    beacon_req,
	// downstream ports (switch only)
	input  wire logic [wepf_pkg::NUM_DS_PORTS-1:0]  ds_active,
	input  wire logic [wepf_pkg::NUM_DS_PORTS-1:0]  ds_fence_ack,
	input  wire logic [wepf_pkg::NUM_DS_PORTS-1:0]  ds_ready,
	output logic                                    ds_fence_fwd,
	// platform pins
	input  wire logic                               main_pwr,
	input  wire logic                               sideband_wake_in,
	output logic                                    wake_line_o,
	output logic                                    wake_line_oe_n
);
	wepf_pkg::wepf_state_t state_q;
	logic [wepf_pkg::TIMER_W-1:0] timer_q;
	logic main_pwr_m_q;
	logic main_pwr_s_q;
	logic sb_in_m_q;
	logic sb_in_s_q;
	logic fence_q;
	logic acked_q;
	logic entering_q;
	logic send_ack;
	logic wake_send;
	logic timeout;
	logic agg_clear;
	wepf_ack_if ack_bus ();

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		main_pwr_m_q <= main_pwr;
		main_pwr_s_q <= main_pwr_m_q;
		sb_in_m_q    <= sideband_wake_in;
		sb_in_s_q    <= sb_in_m_q;
	end

	// ------------------------------------------------------------
	// aux power gate
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			aux_pwr_draw <= 1'b0;
		end else begin
			aux_pwr_draw <= aux_pwr_enable; // see RULE11
		end
	end

	// ------------------------------------------------------------
	// sticky pending status
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst && !(aux_present && wake_event_enable)) begin
			wake_event_pending <= wepf_pkg::PENDING_RST; // see RULE10
		end else if (wake_event_in && wake_event_enable && !fence_q) begin
			wake_event_pending <= 1'b1; // see RULE9
		end else if (pending_clear) begin
			wake_event_pending <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// fence reception and acknowledgement
	// ------------------------------------------------------------
	// ack goes out for any power state; switch waits for all active downstream ports
	assign send_ack = fence_q && !acked_q &&
		(!is_switch || ack_bus.all_acked); // see RULE14 see RULE15 see RULE17

	always_ff @(posedge sys_clk) begin
		if (rst || us_tlp_rx && !power_off_fence_msg) begin
			fence_q <= 1'b0;
		end else if (power_off_fence_msg) begin
			fence_q <= 1'b1; // see RULE13
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || !fence_q) begin
			acked_q <= 1'b0;
		end else if (send_ack) begin
			acked_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			power_off_fence_ack <= 1'b0;
			ds_fence_fwd        <= 1'b0;
		end else begin
			power_off_fence_ack <= send_ack; // see RULE14
			ds_fence_fwd        <= power_off_fence_msg && is_switch;
		end
	end

	// ------------------------------------------------------------
	// downstream acknowledgement aggregation
	// ------------------------------------------------------------
	assign agg_clear = send_ack || us_tlp_rx || !main_pwr_s_q; // see RULE16
	assign ack_bus.ds_ack    = ds_fence_ack;
	assign ack_bus.ds_ready  = ds_ready;
	assign ack_bus.ds_active = ds_active;
	assign ack_bus.clear     = agg_clear;

	wepf_ack_agg u_agg (
		.sys_clk (sys_clk),
		.rst     (rst),
		.agg     (ack_bus.agg)
	);

	// ------------------------------------------------------------
	// ready-for-power-removal entry
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst || !fence_q || !main_pwr_s_q) begin
			entering_q <= 1'b0;
		end else if (acked_q && (!is_switch || ack_bus.all_ready)) begin
			entering_q <= 1'b1; // see RULE18 see RULE19
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || !fence_q || !main_pwr_s_q) begin
			enter_poweroff_ready_pkt <= 1'b0;
			ready_for_power_removal  <= 1'b0;
		end else if (enter_ack_rx && entering_q) begin
			enter_poweroff_ready_pkt <= 1'b0;
			ready_for_power_removal  <= 1'b1;
		end else begin
			// repeat until acknowledged or power goes
			enter_poweroff_ready_pkt <= entering_q && !ready_for_power_removal; // see RULE22
		end
	end

	// ------------------------------------------------------------
	// wake delivery state machine
	// ------------------------------------------------------------
	assign timeout   = (timer_q == wepf_pkg::TIMER_W'(wepf_pkg::RESEND_TIMEOUT_CYC - 1));
	assign wake_send = wake_event_pending && wake_event_enable && link_trained &&
		!fence_q && (state_q == wepf_pkg::WEPF_COMM || state_q == wepf_pkg::WEPF_REACT ||
		(state_q == wepf_pkg::WEPF_SENT && timeout)); // see RULE12 see RULE23

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_q <= wepf_pkg::WEPF_COMM;
		end else begin
			unique case (state_q)
				wepf_pkg::WEPF_COMM: begin
					if (wake_send) begin
						state_q <= wepf_pkg::WEPF_SENT;
					end else if (ready_for_power_removal) begin
						state_q <= wepf_pkg::WEPF_NONCOMM;
					end
				end
				wepf_pkg::WEPF_SENT: begin
					if (!wake_event_pending) begin
						state_q <= wepf_pkg::WEPF_COMM;
					end else if (acked_q) begin
						state_q <= wepf_pkg::WEPF_REACT;
					end else if (timeout && !link_trained) begin
						state_q <= wepf_pkg::WEPF_REACT; // see RULE23
					end
				end
				wepf_pkg::WEPF_NONCOMM: begin
					if (wake_event_pending && wake_event_enable) begin
						state_q <= wepf_pkg::WEPF_REACT; // see RULE1
					end
				end
				wepf_pkg::WEPF_REACT: begin
					if (wake_send) begin
						state_q <= wepf_pkg::WEPF_SENT;
					end
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst || state_q != wepf_pkg::WEPF_SENT || wake_send) begin
			timer_q <= '0;
		end else if (!timeout) begin
			timer_q <= timer_q + 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_request_msg <= 1'b0;
			wake_request_id  <= '0;
		end else begin
			wake_request_msg <= wake_send;
			if (wake_send) begin
				wake_request_id <= requester_id; // see RULE2 see RULE3 see RULE4
			end
		end
	end

	// ------------------------------------------------------------
	// wakeup signalling: sideband line and beacon
	// ------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wake_line_oe_n <= wepf_pkg::WAKE_OE_N_RST; // see RULE7
			wake_line_o    <= 1'b0;
		end else begin
			wake_line_o <= 1'b0; // see RULE24
			if (state_q == wepf_pkg::WEPF_REACT && use_sideband && wake_event_enable &&
				aux_pwr_draw) begin
				wake_line_oe_n <= 1'b0; // see RULE7 see RULE9
			end
		end
	end

	// sideband input only bridged by a switch, never read as wake source
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			beacon_req <= 1'b0;
		end else begin
			beacon_req <= beacon_capable && ((state_q == wepf_pkg::WEPF_REACT &&
				!use_sideband && wake_event_enable && !link_trained) ||
				(is_switch && sb_in_s_q)); // see RULE5 see RULE6 see RULE8
		end
	end
endmodule : wepf_top

/* File: dv/wepf_monitor.sv */
// wepf_monitor: port assertions for wepf_top
// assumes one sys_clk domain, bound into wepf_top
`timescale 1ns/1ps
module wepf_monitor (
	input wire logic                          sys_clk, rst, is_switch,
	input wire logic                          wake_event_enable, aux_pwr_enable, aux_pwr_draw,
	input wire logic                          wake_request_msg, power_off_fence_msg,
	input wire logic                          power_off_fence_ack, us_tlp_rx, enter_ack_rx,
	input wire logic                          enter_poweroff_ready_pkt, main_pwr,
	input wire logic                          ready_for_power_removal, wake_line_o,
	input wire logic                          wake_line_oe_n,
	input wire logic [wepf_pkg::REQ_ID_W-1:0] requester_id, wake_request_id,
	input wire logic [wepf_pkg::NUM_DS_PORTS-1:0] ds_active, ds_ready
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_ack_two_late: assert property (!is_switch && power_off_fence_ack |->
		$past(power_off_fence_msg, 2)) else $error("ack without fence");
	a_id_with_msg: assert property (wake_request_msg |->
		wake_request_id == $past(requester_id)) else $error("bad requester id");
	a_send_enabled: assert property (wake_request_msg |->
		$past(wake_event_enable)) else $error("request while disabled");
	a_fence_blocks: assert property (power_off_fence_msg && !us_tlp_rx |->
		##2 !wake_request_msg [*4]) else $error("request after fence");
	a_entry_repeats: assert property (enter_poweroff_ready_pkt && !enter_ack_rx && main_pwr &&
		!us_tlp_rx |=> enter_poweroff_ready_pkt) else $error("entry dropped");
	a_ready_on_ack: assert property (enter_poweroff_ready_pkt && enter_ack_rx |=>
		ready_for_power_removal && !enter_poweroff_ready_pkt) else $error("no ready");
	a_aux_gated: assert property (aux_pwr_draw |-> $past(aux_pwr_enable))
		else $error("aux drawn unenabled");
	a_wake_held: assert property (!wake_line_oe_n |=> !wake_line_oe_n)
		else $error("wake line released");
	a_line_low: assert property (!wake_line_oe_n |-> !wake_line_o)
		else $error("wake line not low");
	a_sw_ready: assert property (is_switch && $rose(ready_for_power_removal) |->
		$past(&(ds_ready | ~ds_active))) else $error("switch ready early");
endmodule : wepf_monitor
bind wepf_top wepf_monitor i_wepf_monitor (.*);

/* File: dv/wepf_pm_model.sv */
// wepf_pm_model: upstream side answering entry requests
// assumes entry request is a level from wepf_top
`timescale 1ns/1ps
module wepf_pm_model (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// entry handshake
	input  wire logic       enter_poweroff_ready_pkt,
	input  wire logic [3:0] dly,
	output logic            enter_ack_rx
);
	logic [3:0] cnt_q;
	// one acknowledge pulse after dly+1 cycles of requests
	always_ff @(posedge sys_clk) begin
		if (rst || !enter_poweroff_ready_pkt || enter_ack_rx) begin
			cnt_q <= 4'h0;
			enter_ack_rx <= 1'b0;
		end else if (cnt_q == dly) begin
			enter_ack_rx <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 4'h1;
		end
	end
endmodule : wepf_pm_model

/* File: dv/tb_top.sv */
// tb_top: random and corner tests of wepf_top
// assumes wepf_pm_model as the upstream side
`timescale 1ns/1ps
module tb_top;
	logic        sys_clk = 1'b0, rst = 1'b1, is_switch = 1'b0, use_sideband = 1'b0;
	logic        beacon_capable = 1'b1, wake_event_enable = 1'b0, aux_pwr_enable = 1'b0;
	logic        pending_clear = 1'b0, aux_present = 1'b0, wake_event_in = 1'b0;
	logic        link_trained = 1'b0, power_off_fence_msg = 1'b0, us_tlp_rx = 1'b0;
	logic        main_pwr = 1'b1; // power never removed here
	logic        sideband_wake_in = 1'b0, bad;
	logic [15:0] requester_id = 16'h0000, wake_request_id, lf = 16'h0039;
	logic [3:0]  ds_active = 4'h0, ds_fence_ack = 4'h0, ds_ready = 4'h0, dly = 4'h4, acked;
	logic        wake_event_pending, aux_pwr_draw, wake_request_msg, power_off_fence_ack;
	logic        enter_poweroff_ready_pkt, ready_for_power_removal, beacon_req;
	logic        ds_fence_fwd, wake_line_o, wake_line_oe_n, enter_ack_rx;
	int          n_fail = 0, checks_done = 0;
	wire [3:0]   obs = {ready_for_power_removal, power_off_fence_ack, wake_line_oe_n,
		enter_poweroff_ready_pkt};
	wepf_top i_wepf_top (.*);
	wepf_pm_model i_wepf_pm_model (.*);
	initial forever #50 sys_clk = ~sys_clk;
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr
	function automatic logic all_acked(input logic [3:0] act, input logic [3:0] got);
		return &(got | ~act);
	endfunction : all_acked
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#10;
	endtask : step
	task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic finish_test();
		$display("checks %0d fails %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic wait_bit(input int b, input logic v, input string nm);
		int k;
		for (k = 0; k < 60 && obs[b] !== v; k++) step(1);
		chk(nm, obs[b], v);
		if (obs[b] !== v) finish_test();
	endtask : wait_bit
	task automatic wake();
		wake_event_in = 1'b1;
		step(1);
		wake_event_in = 1'b0;
	endtask : wake
	task automatic fence();
		power_off_fence_msg = 1'b1;
		step(1);
		power_off_fence_msg = 1'b0;
	endtask : fence
	task automatic do_rst(input logic a);
		rst = 1'b1;
		aux_present = a;
		step(3);
		rst = 1'b0;
	endtask : do_rst
	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		step(16);
		rst = 1'b0;
		wake_event_enable = 1'b1;
		link_trained = 1'b1;
		for (int i = 0; i < 4; i++) begin
			requester_id = lf;
			lf = lfsr(lf);
			step(1);
			wake();
			chk("pending", wake_event_pending, 1'b1);
			step(1);
			chk("request", wake_request_msg, 1'b1);
			chk("req id", wake_request_id, requester_id);
			pending_clear = 1'b1;
			step(1);
			pending_clear = 1'b0;
			chk("cleared", wake_event_pending, 1'b0);
		end
		$display("test wake send done");
		wake_event_enable = 1'b0;
		wake();
		step(2);
		chk("no pending", wake_event_pending, 1'b0);
		wake_event_enable = 1'b1;
		aux_pwr_enable = 1'b1;
		step(1);
		chk("aux draw", aux_pwr_draw, 1'b1);
		$display("test enables done");
		dly = lf[3:0] | 4'h4;
		fence();
		wake_event_in = 1'b1;
		step(1);
		wake_event_in = 1'b0;
		chk("fence ack", power_off_fence_ack, 1'b1);
		step(2);
		chk("blocked", wake_event_pending, 1'b0);
		wait_bit(0, 1'b1, "entry pkt");
		step(2);
		chk("entry held", enter_poweroff_ready_pkt, 1'b1);
		wait_bit(3, 1'b1, "ready");
		chk("entry done", enter_poweroff_ready_pkt, 1'b0);
		$display("test endpoint fence done");
		do_rst(1'b0);
		use_sideband = 1'b1;
		wake();
		step(2);
		fence();
		wait_bit(1, 1'b0, "wake line");
		step(8);
		chk("line held", wake_line_oe_n, 1'b0);
		chk("line low", wake_line_o, 1'b0);
		do_rst(1'b1);
		chk("released", wake_line_oe_n, 1'b1);
		chk("sticky", wake_event_pending, 1'b1);
		use_sideband = 1'b0;
		is_switch = 1'b1;
		do_rst(1'b0);
		chk("lost", wake_event_pending, 1'b0);
		$display("test sideband done");
		lf = lfsr(lf);
		ds_active = lf[3:0] | 4'h1;
		dly = lf[7:4] | 4'h4;
		acked = 4'h0;
		fence();
		chk("fence fwd", ds_fence_fwd, 1'b1);
		step(1);
		chk("fwd pulse", ds_fence_fwd, 1'b0);
		step(1);
		for (int p = 0; p < 4; p++) begin
			if (ds_active[p]) begin
				ds_fence_ack = 4'h1 << p;
				step(1);
				ds_fence_ack = 4'h0;
				acked[p] = 1'b1;
				if (all_acked(ds_active, acked)) wait_bit(2, 1'b1, "sw ack");
				else begin
					bad = 1'b0;
					repeat (4) begin
						step(1);
						bad = bad | power_off_fence_ack;
					end
					chk("early ack", bad, 1'b0);
				end
			end
		end
		ds_ready = ds_active & 4'hE;
		step(20);
		chk("sw early", ready_for_power_removal, all_acked(ds_active, ds_ready));
		ds_ready = ds_active;
		wait_bit(3, 1'b1, "sw ready");
		sideband_wake_in = 1'b1;
		step(3);
		chk("beacon on", beacon_req, 1'b1);
		sideband_wake_in = 1'b0;
		step(3);
		chk("beacon off", beacon_req, 1'b0);
		us_tlp_rx = 1'b1;
		step(1);
		us_tlp_rx = 1'b0;
		step(1);
		chk("cancel", ready_for_power_removal, 1'b0);
		ds_fence_ack = ds_active;
		step(1);
		ds_fence_ack = 4'h0;
		us_tlp_rx = 1'b1;
		step(1);
		us_tlp_rx = 1'b0;
		fence();
		bad = 1'b0;
		repeat (4) begin
			step(1);
			bad = bad | power_off_fence_ack;
		end
		chk("agg cleared", bad, 1'b0);
		$display("test switch done");
		finish_test();
	end
endmodule : tb_top
